// *** rtl/nvs_handler.sv ***
// Stored-settings command handler with transfer timing sequencer
`timescale 1ns/1ns
// Function
// RULE_01 - On reset, working settings are reloaded from stored settings.
// RULE_02 - Password mode allows stored writes only after the matching password.
// RULE_03 - Working settings change freely whatever the protection.
// RULE_04 - Every command packet gets exactly one response.
// RULE_05 - Chip defaults write is command 0x60, sub-command 0x20.
// RULE_06 - Bytes 4 to 12 give each pin's role.
// RULE_07 - Bytes 13-14 default levels, bytes 15-16 default directions.
// RULE_08 - Byte 17 bit 4 enables remote wake-up.
// RULE_09 - Byte 17 bits 3 to 1 select interrupt counting mode.
// RULE_10 - Byte 17 bit 0 keeps the bus held between transfers.
// RULE_11 - Byte 18 selects open, password or permanent lock.
// RULE_12 - Host sends new password in bytes 19-26, zeros keep it.
// RULE_13 - Host zero-fills bytes 27 to 63.
// RULE_14 - Refused write echoes command, returns 0xFB, stores nothing.
// RULE_15 - Successful write echoes command, returns 0x00, echoes sub-command.
// RULE_16 - SPI defaults write is command 0x60, sub-command 0x10.
// RULE_17 - Bytes 4 to 7 hold the 32-bit bit rate, low first.
// RULE_18 - Bytes 8-9 idle select pattern, bytes 10-11 active pattern.
// RULE_19 - Selects show active pattern during transfer, idle pattern otherwise.
// RULE_20 - Three 16-bit delays in 100 us units at bytes 12-17.
// RULE_21 - Delays applied before first byte, between bytes, after last byte.
// RULE_22 - Bytes 18-19 hold the 16-bit transaction length, low first.
// RULE_23 - Byte 20 selects the SPI clocking mode 0 to 3.
// RULE_24 - SPI defaults write during a transfer is refused with 0xF8.
module nvs_handler #(
  parameter int TICK = nvs_pkg::TICK_CYCLES
) (
  // Clock, reset and power-on reset of the stored image
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  // Command packet byte stream
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  // Password supply and volatile apply
  input wire logic pw_valid,
  input wire logic [63:0] pw_data,
  input wire logic vol_wr,
  // Response
  output logic rsp_valid,
  output logic [7:0] rsp_cmd,
  output logic [7:0] rsp_status,
  output logic [7:0] rsp_sub,
  // Protection state
  output logic [7:0] nv_access,
  output logic pw_unlocked,
  // Working chip settings
  output logic [17:0] pin_role,
  output logic [8:0] dflt_level,
  output logic [8:0] dflt_dir,
  output logic wake_en,
  output logic [2:0] int_mode,
  output logic bus_hold,
  // Working SPI settings
  output logic [31:0] spi_rate,
  output logic [1:0] spi_mode,
  output logic [15:0] xfer_len,
  // Transfer sequencing
  input wire logic xfer_req,
  input wire logic byte_done,
  output logic byte_go,
  output logic xfer_busy,
  output logic [8:0] select_line
);
  logic [7:0] pkt [0:nvs_pkg::PKT_BYTES-1];
  logic [7:0] next_pkt [0:nvs_pkg::PKT_BYTES-1];
  logic [5:0] idx;
  logic [5:0] next_idx;
  logic [7:0] nv_chip [nvs_pkg::B_ROLE0:nvs_pkg::B_CHIP_LAST];
  logic [7:0] next_nv_chip [nvs_pkg::B_ROLE0:nvs_pkg::B_CHIP_LAST];
  logic [7:0] nv_spi [nvs_pkg::S_RATE:nvs_pkg::S_MODE];
  logic [7:0] next_nv_spi [nvs_pkg::S_RATE:nvs_pkg::S_MODE];
  logic [7:0] wk_chip [nvs_pkg::B_ROLE0:nvs_pkg::B_ACC];
  logic [7:0] next_wk_chip [nvs_pkg::B_ROLE0:nvs_pkg::B_ACC];
  logic [7:0] wk_spi [nvs_pkg::S_RATE:nvs_pkg::S_MODE];
  logic [7:0] next_wk_spi [nvs_pkg::S_RATE:nvs_pkg::S_MODE];
  logic load_pend;
  logic exec;
  logic is_chip;
  logic is_spi;
  logic allowed;
  logic pw_zero;
  logic [63:0] pw_stored;
  logic next_unlocked;
  logic next_rsp_valid;
  logic [7:0] next_rsp_cmd;
  logic [7:0] next_rsp_status;
  logic [7:0] next_rsp_sub;

  function automatic logic [15:0] half(input logic [7:0] lo, input logic [7:0] hi);
    half = {hi, lo};
  endfunction

  // Packet assembly and decode
  assign exec = cmd_valid && (idx == 6'(nvs_pkg::PKT_BYTES - 1));
  assign is_chip = (pkt[0] == nvs_pkg::CMD_SET_NV) && (pkt[1] == nvs_pkg::SUB_CHIP); // RULE_05
  assign is_spi = (pkt[0] == nvs_pkg::CMD_SET_NV) && (pkt[1] == nvs_pkg::SUB_SPI); // RULE_16
  assign allowed = (nv_access == nvs_pkg::ACC_OPEN) ||
                   ((nv_access == nvs_pkg::ACC_PW) && pw_unlocked); // RULE_02 RULE_11

  always_comb
  begin
    pw_zero = 1'b1;
    for (int i = 0; i < nvs_pkg::PW_LEN; i++)
    begin
      pw_stored[8*i +: 8] = nv_chip[nvs_pkg::B_PW0 + i];
      if (pkt[nvs_pkg::B_PW0 + i] != 8'h00)
      begin
        pw_zero = 1'b0;
      end
    end
  end

  always_comb
  begin
    next_pkt = pkt;
    next_idx = idx;
    if (cmd_valid)
    begin
      next_pkt[idx] = cmd_data;
      next_idx = idx + 6'h1;
    end
  end

  // Command execution and response
  always_comb
  begin
    next_nv_chip = nv_chip;
    next_nv_spi = nv_spi;
    next_rsp_valid = exec; // RULE_04
    next_rsp_cmd = rsp_cmd;
    next_rsp_status = rsp_status;
    next_rsp_sub = rsp_sub;
    if (exec)
    begin
      next_rsp_cmd = pkt[0]; // RULE_14 RULE_15
      next_rsp_sub = pkt[1]; // RULE_15
      if (!is_chip && !is_spi)
      begin
        next_rsp_status = nvs_pkg::ST_UNSUP;
      end
      else if (!allowed)
      begin
        next_rsp_status = nvs_pkg::ST_BLOCKED; // RULE_14
      end
      else if (is_spi && xfer_busy)
      begin
        next_rsp_status = nvs_pkg::ST_BUSY; // RULE_24
      end
      else if (is_chip)
      begin
        next_rsp_status = nvs_pkg::ST_OK; // RULE_15
        for (int i = nvs_pkg::B_ROLE0; i <= nvs_pkg::B_ACC; i++)
        begin
          next_nv_chip[i] = pkt[i]; // RULE_06 RULE_07 RULE_08 RULE_09 RULE_10 RULE_11
        end
        if (!pw_zero)
        begin
          for (int i = nvs_pkg::B_PW0; i <= nvs_pkg::B_CHIP_LAST; i++)
          begin
            next_nv_chip[i] = pkt[i]; // RULE_12
          end
        end
      end
      else
      begin
        next_rsp_status = nvs_pkg::ST_OK; // RULE_15
        for (int i = nvs_pkg::S_RATE; i <= nvs_pkg::S_MODE; i++)
        begin
          next_nv_spi[i] = pkt[i]; // RULE_17 RULE_18 RULE_20 RULE_22 RULE_23
        end
      end
    end
  end

  // Working copy: reload after reset, else volatile apply
  always_comb
  begin
    next_wk_chip = wk_chip;
    next_wk_spi = wk_spi;
    next_unlocked = pw_unlocked;
    if (pw_valid)
    begin
      next_unlocked = (pw_data == pw_stored); // RULE_02
    end
    if (load_pend)
    begin
      for (int i = nvs_pkg::B_ROLE0; i <= nvs_pkg::B_ACC; i++)
      begin
        next_wk_chip[i] = nv_chip[i]; // RULE_01
      end
      next_wk_spi = nv_spi; // RULE_01
    end
    else if (vol_wr && (pkt[1] == nvs_pkg::SUB_CHIP))
    begin
      for (int i = nvs_pkg::B_ROLE0; i <= nvs_pkg::B_ACC; i++)
      begin
        next_wk_chip[i] = pkt[i]; // RULE_03
      end
    end
    else if (vol_wr && (pkt[1] == nvs_pkg::SUB_SPI))
    begin
      for (int i = nvs_pkg::S_RATE; i <= nvs_pkg::S_MODE; i++)
      begin
        next_wk_spi[i] = pkt[i]; // RULE_03
      end
    end
  end

  always_ff @(posedge clk or posedge por)
  begin
    if (por)
    begin
      for (int i = nvs_pkg::B_ROLE0; i <= nvs_pkg::B_CHIP_LAST; i++)
      begin
        nv_chip[i] <= nvs_pkg::NV_RESET;
      end
      for (int i = nvs_pkg::S_RATE; i <= nvs_pkg::S_MODE; i++)
      begin
        nv_spi[i] <= nvs_pkg::NV_RESET;
      end
    end
    else
    begin
      nv_chip <= next_nv_chip;
      nv_spi <= next_nv_spi;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < nvs_pkg::PKT_BYTES; i++)
      begin
        pkt[i] <= 8'h00;
      end
      for (int i = nvs_pkg::B_ROLE0; i <= nvs_pkg::B_ACC; i++)
      begin
        wk_chip[i] <= 8'h00;
      end
      for (int i = nvs_pkg::S_RATE; i <= nvs_pkg::S_MODE; i++)
      begin
        wk_spi[i] <= 8'h00;
      end
      idx <= 6'h00;
      load_pend <= 1'b1;
      pw_unlocked <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_cmd <= 8'h00;
      rsp_status <= 8'h00;
      rsp_sub <= 8'h00;
    end
    else
    begin
      pkt <= next_pkt;
      wk_chip <= next_wk_chip;
      wk_spi <= next_wk_spi;
      idx <= next_idx;
      load_pend <= 1'b0;
      pw_unlocked <= next_unlocked;
      rsp_valid <= next_rsp_valid;
      rsp_cmd <= next_rsp_cmd;
      rsp_status <= next_rsp_status;
      rsp_sub <= next_rsp_sub;
    end
  end

  // Working settings fields, and protection mode from the stored settings
  assign nv_access = nv_chip[nvs_pkg::B_ACC];
  generate
    for (genvar p = 0; p < nvs_pkg::NUM_PINS; p++)
    begin : g_role
      assign pin_role[2*p +: 2] = wk_chip[nvs_pkg::B_ROLE0 + p][1:0]; // RULE_06
    end
  endgenerate
  assign dflt_level = {wk_chip[nvs_pkg::B_LVL + 1][0], wk_chip[nvs_pkg::B_LVL]}; // RULE_07
  assign dflt_dir = {wk_chip[nvs_pkg::B_DIR + 1][0], wk_chip[nvs_pkg::B_DIR]}; // RULE_07
  assign wake_en = wk_chip[nvs_pkg::B_FLAGS][nvs_pkg::WAKE_BIT]; // RULE_08
  assign int_mode = wk_chip[nvs_pkg::B_FLAGS][nvs_pkg::INT_LSB +: 3]; // RULE_09
  assign bus_hold = wk_chip[nvs_pkg::B_FLAGS][nvs_pkg::HOLD_BIT]; // RULE_10
  assign spi_rate = {wk_spi[nvs_pkg::S_RATE + 3], wk_spi[nvs_pkg::S_RATE + 2],
                     wk_spi[nvs_pkg::S_RATE + 1], wk_spi[nvs_pkg::S_RATE]}; // RULE_17
  assign spi_mode = wk_spi[nvs_pkg::S_MODE][1:0]; // RULE_23
  assign xfer_len = half(wk_spi[nvs_pkg::S_LEN], wk_spi[nvs_pkg::S_LEN + 1]); // RULE_22

  // Transfer sequencer
  nvs_pkg::nvs_seq_t st;
  nvs_pkg::nvs_seq_t next_st;
  logic [15:0] rem;
  logic [15:0] next_rem;
  logic next_byte_go;
  logic [8:0] next_select;
  logic dly_start;
  logic [15:0] dly_units;
  logic dly_done;
  logic [8:0] next_idle_pat;
  logic [8:0] next_act_pat;

  assign next_idle_pat = {next_wk_spi[nvs_pkg::S_IDLE + 1][0], next_wk_spi[nvs_pkg::S_IDLE]}; // RULE_18
  assign next_act_pat = {next_wk_spi[nvs_pkg::S_ACT + 1][0], next_wk_spi[nvs_pkg::S_ACT]}; // RULE_18

  always_comb
  begin
    next_st = st;
    next_rem = rem;
    next_byte_go = 1'b0;
    dly_start = 1'b0;
    dly_units = 16'h0000;
    case (st)
      nvs_pkg::SQ_IDLE:
      begin
        if (xfer_req)
        begin
          next_st = nvs_pkg::SQ_LEAD;
          next_rem = xfer_len;
          dly_start = 1'b1;
          dly_units = half(wk_spi[nvs_pkg::S_LEAD], wk_spi[nvs_pkg::S_LEAD + 1]); // RULE_20 RULE_21
        end
      end
      nvs_pkg::SQ_LEAD, nvs_pkg::SQ_GAP:
      begin
        if (dly_done)
        begin
          if (rem == 16'h0000)
          begin
            next_st = nvs_pkg::SQ_TAIL;
            dly_start = 1'b1;
            dly_units = half(wk_spi[nvs_pkg::S_TAIL], wk_spi[nvs_pkg::S_TAIL + 1]); // RULE_21
          end
          else
          begin
            next_st = nvs_pkg::SQ_BYTE;
            next_byte_go = 1'b1;
          end
        end
      end
      nvs_pkg::SQ_BYTE:
      begin
        if (byte_done)
        begin
          next_rem = rem - 16'h0001;
          dly_start = 1'b1;
          if (rem == 16'h0001)
          begin
            next_st = nvs_pkg::SQ_TAIL;
            dly_units = half(wk_spi[nvs_pkg::S_TAIL], wk_spi[nvs_pkg::S_TAIL + 1]); // RULE_21
          end
          else
          begin
            next_st = nvs_pkg::SQ_GAP;
            dly_units = half(wk_spi[nvs_pkg::S_GAP], wk_spi[nvs_pkg::S_GAP + 1]); // RULE_20 RULE_21
          end
        end
      end
      nvs_pkg::SQ_TAIL:
      begin
        if (dly_done)
        begin
          next_st = nvs_pkg::SQ_IDLE;
        end
      end
      default:
      begin
        next_st = nvs_pkg::SQ_IDLE;
      end
    endcase
    next_select = (next_st != nvs_pkg::SQ_IDLE) ? next_act_pat : next_idle_pat; // RULE_19
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= nvs_pkg::SQ_IDLE;
      rem <= 16'h0000;
      byte_go <= 1'b0;
      xfer_busy <= 1'b0;
      select_line <= 9'h000;
    end
    else
    begin
      st <= next_st;
      rem <= next_rem;
      byte_go <= next_byte_go;
      xfer_busy <= (next_st != nvs_pkg::SQ_IDLE);
      select_line <= next_select;
    end
  end

  nvs_delay #(.TICK(TICK)) u_delay (
    .clk(clk),
    .rst(rst),
    .start(dly_start),
    .units(dly_units),
    .done(dly_done)
  );

  // Checks
  sequence seq_enter_lead;
    (st == nvs_pkg::SQ_IDLE) && xfer_req;
  endsequence
  chk_reload_after_reset: assert property (@(posedge clk) disable iff (rst) // RULE_01
    load_pend |=> (spi_mode == $past(nv_spi[nvs_pkg::S_MODE][1:0])))
    else $error("working settings not reloaded");
  chk_pw_guard: assert property (@(posedge clk) disable iff (rst) // RULE_02
    (exec && is_chip && nv_access == nvs_pkg::ACC_PW && !pw_unlocked) |=> rsp_status == nvs_pkg::ST_BLOCKED)
    else $error("locked write not refused");
  chk_volatile_free: assert property (@(posedge clk) disable iff (rst) // RULE_03
    (vol_wr && !load_pend && pkt[1] == nvs_pkg::SUB_SPI) |=> spi_mode == $past(pkt[nvs_pkg::S_MODE][1:0]))
    else $error("volatile write not applied");
  chk_one_response: assert property (@(posedge clk) disable iff (rst) // RULE_04
    exec |=> rsp_valid ##1 !rsp_valid)
    else $error("response count wrong");
  chk_blocked_nowrite: assert property (@(posedge clk) disable iff (rst || por) // RULE_14
    (exec && is_chip && !allowed) |=> $stable(nv_access) && rsp_cmd == nvs_pkg::CMD_SET_NV)
    else $error("refused write changed storage");
  chk_ok_echo: assert property (@(posedge clk) disable iff (rst) // RULE_15
    (exec && is_chip && allowed) |=> rsp_status == nvs_pkg::ST_OK && rsp_sub == nvs_pkg::SUB_CHIP)
    else $error("success response wrong");
  chk_busy_refuse: assert property (@(posedge clk) disable iff (rst) // RULE_24
    (exec && is_spi && allowed && xfer_busy) |=> rsp_status == nvs_pkg::ST_BUSY)
    else $error("busy write not refused");
  chk_cs_levels: assert property (@(posedge clk) disable iff (rst) // RULE_19
    xfer_busy |-> select_line == {wk_spi[nvs_pkg::S_ACT + 1][0], wk_spi[nvs_pkg::S_ACT]})
    else $error("select lines not at active pattern");
  chk_lead_delay: assert property (@(posedge clk) disable iff (rst) // RULE_21
    seq_enter_lead |=> (st == nvs_pkg::SQ_LEAD) && !byte_go ##1 !byte_go)
    else $error("byte started before lead delay");
endmodule

// *** rtl/nvs_pkg.sv ***
// Constants and types for the stored-settings command handler
package nvs_pkg;
  // Packet framing
  localparam int PKT_BYTES = 64;
  localparam logic [7:0] CMD_SET_NV = 8'h60;
  localparam logic [7:0] SUB_CHIP = 8'h20;
  localparam logic [7:0] SUB_SPI = 8'h10;
  // Response status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BLOCKED = 8'hFB;
  localparam logic [7:0] ST_BUSY = 8'hF8;
  localparam logic [7:0] ST_UNSUP = 8'hFF;
  // Protection modes
  localparam logic [7:0] ACC_OPEN = 8'h00;
  localparam logic [7:0] ACC_PW = 8'h40;
  localparam logic [7:0] ACC_LOCK = 8'h80;
  // Pin roles
  localparam logic [1:0] ROLE_GPIO = 2'h0;
  localparam logic [1:0] ROLE_SELECT = 2'h1;
  localparam logic [1:0] ROLE_DEDICATED = 2'h2;
  // Chip-settings byte positions
  localparam int NUM_PINS = 9;
  localparam int B_ROLE0 = 4;
  localparam int B_LVL = 13;
  localparam int B_DIR = 15;
  localparam int B_FLAGS = 17;
  localparam int B_ACC = 18;
  localparam int B_PW0 = 19;
  localparam int PW_LEN = 8;
  localparam int B_CHIP_LAST = 26;
  // Flag bit positions in the chip flags byte
  localparam int WAKE_BIT = 4;
  localparam int INT_LSB = 1;
  localparam int HOLD_BIT = 0;
  // SPI-settings byte positions
  localparam int S_RATE = 4;
  localparam int S_IDLE = 8;
  localparam int S_ACT = 10;
  localparam int S_LEAD = 12;
  localparam int S_TAIL = 14;
  localparam int S_GAP = 16;
  localparam int S_LEN = 18;
  localparam int S_MODE = 20;
  // Factory value of every stored byte
  localparam logic [7:0] NV_RESET = 8'h00;
  // Delay unit
  localparam int DELAY_UNIT_US = 100;
  localparam int CLK_MHZ = 20;
  localparam int TICK_CYCLES = DELAY_UNIT_US * CLK_MHZ;
  // Transfer sequencer states, Gray in listed order; BYTE to TAIL and TAIL to IDLE change two bits, LEAD to TAIL three
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000,
    SQ_LEAD = 3'b001,
    SQ_BYTE = 3'b011,
    SQ_GAP = 3'b010,
    SQ_TAIL = 3'b110
  } nvs_seq_t;
endpackage

// *** rtl/nvs_delay.sv ***
// Delay timer counting units of a fixed number of clock cycles
`timescale 1ns/1ns
module nvs_delay #(
  parameter int TICK = nvs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic start,
  input wire logic [15:0] units,
  // Result
  output logic done
);
  generate
    if (TICK < 1)
    begin : g_bad_tick
      $error("TICK must be at least one cycle");
    end
  endgenerate

  logic active;
  logic [15:0] left;
  logic [31:0] tick;
  logic next_active;
  logic [15:0] next_left;
  logic [31:0] next_tick;
  logic next_done;

  always_comb
  begin
    next_active = active;
    next_left = left;
    next_tick = tick;
    next_done = 1'b0;
    if (start)
    begin
      next_active = 1'b1;
      next_left = units;
      next_tick = 32'h0;
    end
    else if (active)
    begin
      if (left == 16'h0)
      begin
        next_active = 1'b0;
        next_done = 1'b1;
      end
      else if (tick == 32'(TICK - 1))
      begin
        next_tick = 32'h0;
        next_left = left - 16'h1;
      end
      else
      begin
        next_tick = tick + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active <= 1'b0;
      left <= 16'h0;
      tick <= 32'h0;
      done <= 1'b0;
    end
    else
    begin
      active <= next_active;
      left <= next_left;
      tick <= next_tick;
      done <= next_done;
    end
  end
endmodule

// *** bench/nvs_host_model.sv ***
// Host packet sender and byte shifter stand-in
`timescale 1ns/1ns
module nvs_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command stream
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  // Shifter handshake
  input wire logic byte_go,
  output logic byte_done,
  input wire logic [3:0] lag
);
  int wait_cnt;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
  end
  // Whole packet, back to back, reserved bytes zeroed
  task automatic send(input logic [511:0] p);
    logic [7:0] b;
    for (int i = 0; i < nvs_pkg::PKT_BYTES; i++)
    begin
      b = p[8*i +: 8];
      if (i == 2 || i == 3) b = 8'h00;
      if (p[15:8] == nvs_pkg::SUB_CHIP && i > nvs_pkg::B_CHIP_LAST) b = 8'h00;
      if (p[15:8] == nvs_pkg::SUB_SPI && i > nvs_pkg::S_MODE) b = 8'h00;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_data = b;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_data = ~cmd_data;
  endtask
  // Byte finishes lag + 1 cycles after each go is seen
  always @(negedge clk)
  begin
    byte_done <= 1'b0;
    if (rst)
      wait_cnt <= 0;
    else if (byte_go === 1'b1)
      wait_cnt <= int'(lag) + 1;
    else if (wait_cnt == 1)
    begin
      byte_done <= 1'b1;
      wait_cnt <= 0;
    end
    else if (wait_cnt > 1)
      wait_cnt <= wait_cnt - 1;
  end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the stored-settings command handler
`timescale 1ns/1ns
module tb;
  localparam int TICK_SIM = 4;
  localparam logic [63:0] PW = 64'h3736353433323130;
  logic clk, rst, por, pw_valid, vol_wr, xfer_req, cmd_valid, byte_done;
  logic [63:0] pw_data;
  logic [3:0] lag;
  logic [7:0] cmd_data, rsp_cmd, rsp_status, rsp_sub, nv_access;
  logic rsp_valid, byte_go, xfer_busy, pw_unlocked, wake_en, bus_hold;
  logic [17:0] pin_role;
  logic [8:0] dflt_level, dflt_dir, select_line;
  logic [2:0] int_mode;
  logic [31:0] spi_rate;
  logic [1:0] spi_mode;
  logic [15:0] xfer_len;
  int error_cnt = 0, samples_checked = 0, cycles = 0, rsp_cnt = 0, seed;
  // Reference model state
  logic [7:0] nv_c [64], nv_s [64], wk_c [64], wk_s [64], pk [64];
  logic [7:0] m_acc;
  logic [63:0] m_pw;
  logic m_unl;

  nvs_handler #(.TICK(TICK_SIM)) u_nvs_handler (.clk(clk), .rst(rst), .por(por), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .pw_valid(pw_valid), .pw_data(pw_data), .vol_wr(vol_wr), .rsp_valid(rsp_valid),
    .rsp_cmd(rsp_cmd), .rsp_status(rsp_status), .rsp_sub(rsp_sub), .nv_access(nv_access),
    .pw_unlocked(pw_unlocked), .pin_role(pin_role), .dflt_level(dflt_level), .dflt_dir(dflt_dir),
    .wake_en(wake_en), .int_mode(int_mode), .bus_hold(bus_hold), .spi_rate(spi_rate), .spi_mode(spi_mode),
    .xfer_len(xfer_len), .xfer_req(xfer_req), .byte_done(byte_done), .byte_go(byte_go),
    .xfer_busy(xfer_busy), .select_line(select_line));
  nvs_host_model u_nvs_host_model (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .byte_go(byte_go), .byte_done(byte_done), .lag(lag));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rsp_valid === 1'b1) rsp_cnt <= rsp_cnt + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_work();
    logic [17:0] r;
    for (int p = 0; p < 9; p++) r[2*p +: 2] = wk_c[4+p][1:0];
    check("roles", pin_role, r);
    check("levels", dflt_level, {wk_c[14][0], wk_c[13]});
    check("dirs", dflt_dir, {wk_c[16][0], wk_c[15]});
    check("wake", wake_en, wk_c[17][4]);
    check("int mode", int_mode, wk_c[17][3:1]);
    check("hold", bus_hold, wk_c[17][0]);
    check("access", nv_access, m_acc);
    check("rate", spi_rate, {wk_s[7], wk_s[6], wk_s[5], wk_s[4]});
    check("mode", spi_mode, wk_s[20][1:0]);
    check("length", xfer_len, {wk_s[19], wk_s[18]});
    if (xfer_busy === 1'b0) check("idle select", select_line, {wk_s[9][0], wk_s[8]});
  endtask

  task automatic do_rst(input logic full);
    @(negedge clk);
    rst = 1'b1;
    por = full;
    if (full)
    begin
      foreach (nv_c[i]) nv_c[i] = 8'h00;
      nv_s = nv_c;
      m_acc = 8'h00;
      m_pw = 64'h0;
    end
    repeat (2) @(negedge clk);
    rst = 1'b0;
    por = 1'b0;
    repeat (3) @(negedge clk);
    wk_c = nv_c;
    wk_s = nv_s;
    m_unl = 1'b0;
    chk_work();
  endtask

  task automatic clr(input logic [7:0] sub);
    foreach (pk[i]) pk[i] = 8'h00;
    pk[0] = nvs_pkg::CMD_SET_NV;
    pk[1] = sub;
  endtask

  task automatic mk_chip(input logic [7:0] acc, input logic [63:0] pw, input logic [2:0] m);
    logic [7:0] r;
    clr(nvs_pkg::SUB_CHIP);
    for (int i = 4; i < 18; i++)
    begin
      r = 8'($random(seed));
      pk[i] = (i < 13) ? {6'h00, (r[1:0] == 2'h3) ? 2'h2 : r[1:0]} : r;
    end
    pk[17] = {pk[17][7:4], m, pk[17][0]};
    pk[18] = acc;
    for (int i = 0; i < 8; i++) pk[19+i] = pw[8*i +: 8];
  endtask

  task automatic mk_spi(input int lead, input int tail, input int gap, input int len);
    clr(nvs_pkg::SUB_SPI);
    for (int i = 4; i < 12; i++) pk[i] = 8'($random(seed));
    {pk[13], pk[12]} = 16'(lead);
    {pk[15], pk[14]} = 16'(tail);
    {pk[17], pk[16]} = 16'(gap);
    {pk[19], pk[18]} = 16'(len);
    pk[20] = {6'h00, 2'($random(seed))};
  endtask

  task automatic do_cmd(input logic vol);
    logic [7:0] st;
    logic [511:0] f;
    int n;
    for (int i = 0; i < 64; i++) f[8*i +: 8] = pk[i];
    if (pk[0] != nvs_pkg::CMD_SET_NV || (pk[1] != nvs_pkg::SUB_CHIP && pk[1] != nvs_pkg::SUB_SPI))
      st = nvs_pkg::ST_UNSUP;
    else if (m_acc != nvs_pkg::ACC_OPEN && !(m_acc == nvs_pkg::ACC_PW && m_unl))
      st = nvs_pkg::ST_BLOCKED;
    else if (pk[1] == nvs_pkg::SUB_SPI && xfer_busy === 1'b1)
      st = nvs_pkg::ST_BUSY;
    else
      st = nvs_pkg::ST_OK;
    if (st == nvs_pkg::ST_OK && pk[1] == nvs_pkg::SUB_CHIP)
    begin
      nv_c = pk;
      m_acc = pk[18];
      if (f[215:152] != 64'h0) m_pw = f[215:152];
    end
    if (st == nvs_pkg::ST_OK && pk[1] == nvs_pkg::SUB_SPI) nv_s = pk;
    n = rsp_cnt;
    u_nvs_host_model.send(f);
    for (int t = 0; t < 8 && rsp_cnt == n; t++) @(negedge clk);
    repeat (2) @(negedge clk);
    check("responses", 32'(rsp_cnt - n), 32'h1);
    check("rsp cmd", rsp_cmd, pk[0]);
    check("rsp status", rsp_status, st);
    check("rsp sub", rsp_sub, pk[1]);
    if (vol)
    begin
      vol_wr = 1'b1;
      @(negedge clk);
      vol_wr = 1'b0;
      repeat (2) @(negedge clk);
      if (pk[1] == nvs_pkg::SUB_CHIP) wk_c = pk;
      else wk_s = pk;
      chk_work();
    end
  endtask

  task automatic give_pw(input logic [63:0] p);
    pw_data = p;
    pw_valid = 1'b1;
    @(negedge clk);
    pw_valid = 1'b0;
    repeat (2) @(negedge clk);
    m_unl = (p == m_pw);
    check("unlock", pw_unlocked, m_unl);
  endtask

  task automatic do_xfer(input logic probe);
    int go, t, lead, tail, gap, len;
    logic [8:0] act;
    lead = {wk_s[13], wk_s[12]};
    tail = {wk_s[15], wk_s[14]};
    gap = {wk_s[17], wk_s[16]};
    len = {wk_s[19], wk_s[18]};
    act = {wk_s[11][0], wk_s[10]};
    go = 0;
    xfer_req = 1'b1;
    @(negedge clk);
    xfer_req = 1'b0;
    check("busy", xfer_busy, 1'b1);
    check("active select", select_line, act);
    if (probe)
    begin
      mk_spi(1, 1, 1, 1);
      do_cmd(1'b0);
    end
    for (t = 1; t < 5000 && xfer_busy === 1'b1; t++)
    begin
      @(negedge clk);
      if (byte_go === 1'b1) go++;
      if (go == 1 && byte_go === 1'b1) check("lead time", t, lead * TICK_SIM + 2);
      if (xfer_busy === 1'b1 && select_line !== act) check("held select", select_line, act);
    end
    check("bytes sent", go, len);
    if (!probe) check("busy time", t >= (lead + tail + gap * (len - 1)) * TICK_SIM + len * lag, 1'b1);
    chk_work();
  endtask

  initial
  begin
    rst = 1'b1;
    por = 1'b1;
    pw_valid = 1'b0;
    pw_data = 64'h0;
    vol_wr = 1'b0;
    xfer_req = 1'b0;
    lag = 4'h1;
    seed = 32'h3e96;
    do_rst(1'b1);
    mk_spi(2, 3, 1, 3);
    do_cmd(1'b0);
    do_rst(1'b0);
    do_xfer(1'b0);
    lag = 4'h6;
    do_xfer(1'b0);
    mk_spi(40, 1, 0, 0);
    do_cmd(1'b1);
    do_xfer(1'b1);
    do_rst(1'b0);
    for (int m = 0; m < 5; m++)
    begin
      mk_chip(nvs_pkg::ACC_OPEN, 64'h0, 3'(m));
      do_cmd(1'b1);
    end
    mk_chip(nvs_pkg::ACC_PW, PW, 3'h2);
    do_cmd(1'b0);
    chk_work();
    do_rst(1'b0);
    mk_chip(nvs_pkg::ACC_OPEN, 64'h0, 3'h1);
    do_cmd(1'b1);
    give_pw(~PW);
    do_cmd(1'b0);
    give_pw(PW);
    mk_chip(nvs_pkg::ACC_LOCK, 64'h0, 3'h4);
    do_cmd(1'b0);
    do_rst(1'b0);
    mk_spi(1, 1, 1, 1);
    do_cmd(1'b1);
    clr(nvs_pkg::SUB_SPI);
    pk[0] = 8'h61;
    do_cmd(1'b0);
    finish_test();
  end
endmodule
